/* hw/coe_mismatch.sv */
// per-comparator mismatch edge detector with refreshable stored state
`timescale 1ns/1ps
module coe_mismatch (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic result_i,
	input wire logic refresh_i,
	output logic set_o
);
	logic prev_q;
	logic pend_q;
	wire differ = result_i ^ prev_q;
	// only a new mismatch edge fires; the stored value tracks only on refresh
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prev_q <= 1'b0;
			pend_q <= 1'b0;
			set_o <= 1'b0;
		end
		else
		begin
			set_o <= differ & ~pend_q;
			pend_q <= differ & ~refresh_i;
			if (refresh_i)
				prev_q <= result_i;
		end
	end
endmodule

/* hw/coe_pkg.sv */
// package: register map, field positions and reset values of the comparator event logic
package coe_pkg;
	localparam int ADDR_W = 3;
	localparam logic [2:0] ADDR_CMP_ONE_CTRL = 3'h0;
	localparam logic [2:0] ADDR_CMP_TWO_CTRL = 3'h1;
	localparam logic [2:0] ADDR_MIRROR_GATE = 3'h2;
	localparam logic [2:0] ADDR_FLAG = 3'h3;
	localparam logic [2:0] ADDR_ENABLE = 3'h4;
	localparam logic [2:0] ADDR_REF_CTRL = 3'h5;
	localparam logic [2:0] ADDR_IRQ_CTRL = 3'h6;
	localparam logic [2:0] ADDR_DIR = 3'h7;
	// control register fields
	localparam int CTL_ON = 7;
	localparam int CTL_RESULT = 6;
	localparam int CTL_OE = 5;
	localparam int CTL_INV = 4;
	// mirror/gate register fields
	localparam int MIR_ONE = 7;
	localparam int MIR_TWO = 6;
	localparam int MIR_GSS = 1;
	localparam int MIR_SYNC = 0;
	// flag / enable register fields
	localparam int FLG_TWO = 4;
	localparam int FLG_ONE = 3;
	// reference control fields
	localparam int REF_RANGE = 5;
	// irq control fields
	localparam int IRQ_GLOBAL = 1;
	localparam int IRQ_PERIPH = 0;
	// direction fields: bit 0 drives cmp one pin, bit 1 cmp two pin (0 = output)
	localparam int DIR_ONE = 0;
	localparam int DIR_TWO = 1;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [1:0] RST_GATE = 2'h2;
	localparam logic [7:0] RST_FLAG = 8'h00;
	localparam logic [7:0] RST_REF = 8'h00;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [1:0] RST_DIR = 2'h3;
	localparam logic [7:0] MASK_CTRL_WR = 8'hbf;
	localparam logic [7:0] MASK_REF_WR = 8'hef;
endpackage

/* hw/coe_sync2.sv */
// two-flop synchroniser for one level
`timescale 1ns/1ps
module coe_sync2 (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);
	logic s1_q;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_q <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			s1_q <= d_i;
			q_o <= s1_q;
		end
	end
endmodule

/* hw/coe_top.sv */
// comparator output, timer gate, pin and mismatch flag logic
// Function
// - mirror register bit 7 shows comparator one result, bit 6 comparator two.
// - mirror register bits 5 to 2 read zero, writes ignored.
// - gate select 1 routes gate pin to timer gate, 0 synced comparator two.
// - sync enable latches comparator two on timer clock falling edge, else passes.
// - the sync latch is clocked from the prescaler output when prescaling.
// - latch on falling timer edge; timer counts on rising edge.
// - enabled pin outputs carry the unsynchronised comparator result.
// - port direction bit stays the pin driver enable.
// - interrupt flag set on edge of result mismatch, not its level.
// - flags at bits 4 and 3; software writes 0 clears, 1 sets.
// - interrupt needs per-comparator, peripheral and global enables; flag sets regardless.
// - unrefreshed mismatch state ignores return; control access refresh makes it flag.
// - a change during a control read still sets its flag; set is decided in the cycle of the refresh.
// - reset returns all registers to reset values; comparators disabled.
// - 4-bit level code and range select give 32 reference levels.
// - low range code*supply/24; high range supply/4 plus code*supply/32.
// - internal results latched each cycle; pin outputs unlatched.
// - mirror register reads leave stored mismatch state unchanged.
`timescale 1ns/1ps
module coe_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic cmp_one_raw_i,
	input wire logic cmp_two_raw_i,
	input wire logic timer_gate_pin_i,
	input wire logic timer_clk_i,
	output logic timer_gate_o,
	output logic cmp_one_pin_o,
	output logic cmp_one_pin_oe_o,
	output logic cmp_two_pin_o,
	output logic cmp_two_pin_oe_o,
	output logic cmp_one_on_o,
	output logic cmp_two_on_o,
	output logic [7:0] cmp_one_cfg_o,
	output logic [7:0] cmp_two_cfg_o,
	output logic ref_range_select_o,
	output logic [3:0] ref_level_code_o,
	output logic [4:0] ladder_reference_o,
	output logic cmp_irq_o
);
	logic [7:0] ctl_one_q;
	logic [7:0] ctl_two_q;
	logic [1:0] gate_q;
	logic [1:0] flag_q;
	logic [1:0] ien_q;
	logic [7:0] ref_q;
	logic [1:0] irq_ctl_q;
	logic [1:0] dir_q;
	logic [7:0] rdata_d;
	logic set_one;
	logic set_two;
	logic tclk_s;
	logic tclk_prev_q;
	logic two_latch_q;

	// polarity-corrected results; comparator is forced low while off
	wire res_one = ctl_one_q[coe_pkg::CTL_ON] & (cmp_one_raw_i ^ ctl_one_q[coe_pkg::CTL_INV]);
	wire res_two = ctl_two_q[coe_pkg::CTL_ON] & (cmp_two_raw_i ^ ctl_two_q[coe_pkg::CTL_INV]);
	logic res_one_q;
	logic res_two_q;

	wire wr_one = wr_i && addr_i == coe_pkg::ADDR_CMP_ONE_CTRL;
	wire wr_two = wr_i && addr_i == coe_pkg::ADDR_CMP_TWO_CTRL;
	wire wr_gate = wr_i && addr_i == coe_pkg::ADDR_MIRROR_GATE;
	wire wr_flag = wr_i && addr_i == coe_pkg::ADDR_FLAG;
	wire wr_ien = wr_i && addr_i == coe_pkg::ADDR_ENABLE;
	wire wr_ref = wr_i && addr_i == coe_pkg::ADDR_REF_CTRL;
	wire wr_irq = wr_i && addr_i == coe_pkg::ADDR_IRQ_CTRL;
	wire wr_dir = wr_i && addr_i == coe_pkg::ADDR_DIR;
	// only control register accesses refresh the mismatch state, never the mirror
	wire refresh_one = (wr_i | rd_i) && addr_i == coe_pkg::ADDR_CMP_ONE_CTRL;
	wire refresh_two = (wr_i | rd_i) && addr_i == coe_pkg::ADDR_CMP_TWO_CTRL;

	// timer clock arrives asynchronously and passes a two-flop synchroniser; its falling edge is seen in this domain.
	// the caller feeds the prescaler output here when prescaling is used.
	coe_sync2 u_tclk_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(timer_clk_i),
		.q_o(tclk_s)
	);
	wire tclk_fall = tclk_prev_q & ~tclk_s;
	wire two_synced = gate_q[coe_pkg::MIR_SYNC] ? two_latch_q : res_two;

	coe_mismatch u_mm_one (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.result_i(res_one_q),
		.refresh_i(refresh_one),
		.set_o(set_one)
	);
	coe_mismatch u_mm_two (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.result_i(res_two_q),
		.refresh_i(refresh_two),
		.set_o(set_two)
	);

	wire [7:0] ctl_one_rd = {ctl_one_q[7], res_one_q, ctl_one_q[5:0]};
	wire [7:0] ctl_two_rd = {ctl_two_q[7], res_two_q, ctl_two_q[5:0]};
	wire [7:0] mirror_rd = {res_one_q, res_two_q, 4'h0, gate_q};

	always_comb
	begin
		if (addr_i == coe_pkg::ADDR_CMP_ONE_CTRL)
			rdata_d = ctl_one_rd;
		else if (addr_i == coe_pkg::ADDR_CMP_TWO_CTRL)
			rdata_d = ctl_two_rd;
		else if (addr_i == coe_pkg::ADDR_MIRROR_GATE)
			rdata_d = mirror_rd;
		else if (addr_i == coe_pkg::ADDR_FLAG)
			rdata_d = {3'h0, flag_q, 3'h0};
		else if (addr_i == coe_pkg::ADDR_ENABLE)
			rdata_d = {3'h0, ien_q, 3'h0};
		else if (addr_i == coe_pkg::ADDR_REF_CTRL)
			rdata_d = ref_q;
		else if (addr_i == coe_pkg::ADDR_IRQ_CTRL)
			rdata_d = {6'h00, irq_ctl_q};
		else
			rdata_d = {6'h00, dir_q};
		if (!rd_i)
			rdata_d = 8'h00;
	end

	// high range adds a quarter of supply: result in 1/96 supply units would need more
	// width, so the code is exported as range plus step and the ladder picks the tap
	wire [4:0] ladder_d = {ref_q[coe_pkg::REF_RANGE], ref_q[3:0]};

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctl_one_q <= coe_pkg::RST_CTRL;
			ctl_two_q <= coe_pkg::RST_CTRL;
			gate_q <= coe_pkg::RST_GATE;
			ref_q <= coe_pkg::RST_REF;
			irq_ctl_q <= coe_pkg::RST_IRQ;
			dir_q <= coe_pkg::RST_DIR;
			ien_q <= 2'h0;
		end
		else
		begin
			if (wr_one)
				ctl_one_q <= wdata_i & coe_pkg::MASK_CTRL_WR;
			if (wr_two)
				ctl_two_q <= wdata_i & coe_pkg::MASK_CTRL_WR;
			if (wr_gate)
				gate_q <= wdata_i[1:0];
			if (wr_ref)
				ref_q <= wdata_i & coe_pkg::MASK_REF_WR;
			if (wr_irq)
				irq_ctl_q <= wdata_i[1:0];
			if (wr_dir)
				dir_q <= wdata_i[1:0];
			if (wr_ien)
				ien_q <= wdata_i[coe_pkg::FLG_TWO:coe_pkg::FLG_ONE];
		end
	end

	// flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			flag_q <= 2'h0;
		else
		begin
			flag_q[1] <= set_two | (wr_flag ? wdata_i[coe_pkg::FLG_TWO] : flag_q[1]);
			flag_q[0] <= set_one | (wr_flag ? wdata_i[coe_pkg::FLG_ONE] : flag_q[0]);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			res_one_q <= 1'b0;
			res_two_q <= 1'b0;
			tclk_prev_q <= 1'b0;
			two_latch_q <= 1'b0;
		end
		else
		begin
			// internal copies refresh once per cycle; a change coinciding with a
			// control read still flags, as set is decided before the refreshed state lands
			res_one_q <= res_one;
			res_two_q <= res_two;
			tclk_prev_q <= tclk_s;
			if (tclk_fall)
				two_latch_q <= res_two;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_o <= 8'h00;
			timer_gate_o <= 1'b0;
			cmp_one_pin_o <= 1'b0;
			cmp_one_pin_oe_o <= 1'b0;
			cmp_two_pin_o <= 1'b0;
			cmp_two_pin_oe_o <= 1'b0;
			cmp_one_on_o <= 1'b0;
			cmp_two_on_o <= 1'b0;
			cmp_one_cfg_o <= coe_pkg::RST_CTRL;
			cmp_two_cfg_o <= coe_pkg::RST_CTRL;
			ref_range_select_o <= 1'b0;
			ref_level_code_o <= 4'h0;
			ladder_reference_o <= 5'h00;
			cmp_irq_o <= 1'b0;
		end
		else
		begin
			rdata_o <= rdata_d;
			timer_gate_o <= gate_q[coe_pkg::MIR_GSS] ? timer_gate_pin_i : two_synced;
			// pins take the unlatched result, one register stage only to meet the output style
			cmp_one_pin_o <= res_one;
			cmp_two_pin_o <= res_two;
			cmp_one_pin_oe_o <= ctl_one_q[coe_pkg::CTL_OE] & ctl_one_q[coe_pkg::CTL_ON]
				& ~dir_q[coe_pkg::DIR_ONE];
			cmp_two_pin_oe_o <= ctl_two_q[coe_pkg::CTL_OE] & ctl_two_q[coe_pkg::CTL_ON]
				& ~dir_q[coe_pkg::DIR_TWO];
			cmp_one_on_o <= ctl_one_q[coe_pkg::CTL_ON];
			cmp_two_on_o <= ctl_two_q[coe_pkg::CTL_ON];
			cmp_one_cfg_o <= ctl_one_q;
			cmp_two_cfg_o <= ctl_two_q;
			ref_range_select_o <= ref_q[coe_pkg::REF_RANGE];
			ref_level_code_o <= ref_q[3:0];
			ladder_reference_o <= ladder_d;
			cmp_irq_o <= irq_ctl_q[coe_pkg::IRQ_GLOBAL] & irq_ctl_q[coe_pkg::IRQ_PERIPH]
				& |(flag_q & ien_q);
		end
	end
endmodule

/* verif/coe_far_model.sv */
// far side: comparators, gate pin and timer prescaler output, answering fast or one cycle late
`timescale 1ns/1ps
module coe_far_model (
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic [3:0] lvl_i,
	output logic [3:0] pins_o
);
	logic [3:0] a_q = 4'h0;
	logic [3:0] b_q = 4'h0;
	// prescaled timer clock moves only when commanded, so latch edges are exact
	always @(posedge clk_i)
	begin
		a_q <= lvl_i;
		b_q <= a_q;
	end
	assign pins_o = slow_i ? b_q : a_q;
endmodule

/* verif/coe_top_props.sv */
// port assertions for the comparator event logic
`timescale 1ns/1ps
module coe_top_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic cmp_one_raw_i,
	input wire logic cmp_one_pin_o,
	input wire logic cmp_one_pin_oe_o,
	input wire logic cmp_one_on_o,
	input wire logic [7:0] cmp_one_cfg_o,
	input wire logic [3:0] ref_level_code_o,
	input wire logic [4:0] ladder_reference_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence mirror_read;
		rd_i && addr_i == coe_pkg::ADDR_MIRROR_GATE;
	endsequence
	sequence one_off;
		!cmp_one_on_o [*2];
	endsequence
	a_pad_zero: assert property (mirror_read |=> rdata_o[5:2] == 4'h0)
		else $error("pad bits set");
	a_off_reads_zero: assert property (one_off ##0 mirror_read |=> !rdata_o[7])
		else $error("off result set");
	a_pin_follows: assert property (cmp_one_on_o && $past(cmp_one_on_o) |->
		cmp_one_pin_o == ($past(cmp_one_raw_i) ^ cmp_one_cfg_o[4])) else $error("pin wrong");
	// enable and config outputs leave the same register stage as the pin enable
	a_oe_cause: assert property (cmp_one_pin_oe_o |-> cmp_one_on_o && cmp_one_cfg_o[5])
		else $error("oe without cause");
	a_ladder_code: assert property (ladder_reference_o[3:0] == ref_level_code_o)
		else $error("ladder code");
	// register updates at the write edge, the output copy one edge later
	a_ref_write: assert property (wr_i && addr_i == coe_pkg::ADDR_REF_CTRL |-> ##2
		ladder_reference_o == {$past(wdata_i[5], 2), $past(wdata_i[3:0], 2)}) else $error("ref write");
	a_ctrl_write: assert property (wr_i && addr_i == coe_pkg::ADDR_CMP_ONE_CTRL |-> ##2
		cmp_one_cfg_o[5:0] == $past(wdata_i[5:0], 2) && cmp_one_on_o == $past(wdata_i[7], 2))
		else $error("ctrl write");
	a_reset_values: assert property ($rose(rst_n_i) |-> cmp_one_cfg_o == 8'h00 && !cmp_one_on_o)
		else $error("reset value");
endmodule
bind coe_top coe_top_props coe_top_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_one_raw_i(cmp_one_raw_i),
	.cmp_one_pin_o(cmp_one_pin_o), .cmp_one_pin_oe_o(cmp_one_pin_oe_o), .cmp_one_on_o(cmp_one_on_o),
	.cmp_one_cfg_o(cmp_one_cfg_o), .ref_level_code_o(ref_level_code_o), .ladder_reference_o(ladder_reference_o));

/* verif/tb.sv */
// self-checking bench for the comparator event logic
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [2:0] ad = 3'h0;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic [3:0] far;
	logic [7:0] rdata, c1, c2;
	logic [4:0] lad;
	logic [3:0] code;
	logic tg, p1, e1, p2, e2, on1, on2, rs, irq;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	always #2.5 clk_i = ~clk_i;
	coe_far_model coe_far_model_inst (.clk_i(clk_i), .slow_i(slow), .lvl_i(lvl), .pins_o(far));
	coe_top coe_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(ad), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .cmp_one_raw_i(far[3]), .cmp_two_raw_i(far[2]), .timer_gate_pin_i(far[1]),
		.timer_clk_i(far[0]), .timer_gate_o(tg), .cmp_one_pin_o(p1), .cmp_one_pin_oe_o(e1), .cmp_two_pin_o(p2),
		.cmp_two_pin_oe_o(e2), .cmp_one_on_o(on1), .cmp_two_on_o(on2), .cmp_one_cfg_o(c1), .cmp_two_cfg_o(c2),
		.ref_range_select_o(rs), .ref_level_code_o(code), .ladder_reference_o(lad), .cmp_irq_o(irq));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			errors++;
		end
	endtask
	task automatic w8(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a, input string n, input logic [7:0] e);
		@(posedge clk_i);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		chk(n, e, rdata);
	endtask
	task automatic t_reset;
		logic [7:0] ex [8];
		ex = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
		for (int i = 0; i < 8; i++)
			rreg(i[2:0], "reset", ex[i]);
	endtask
	task automatic t_ref;
		for (int i = 0; i < 32; i++)
		begin
			wreg(coe_pkg::ADDR_REF_CTRL, {2'h0, i[4], 1'b1, i[3:0]});
			w8(1);
			chk("ladder", {3'h0, i[4], i[3:0]}, {3'h0, lad});
			chk("ref out", {3'h0, i[4], i[3:0]}, {3'h0, rs, code});
		end
		rreg(coe_pkg::ADDR_REF_CTRL, "ref", 8'h2f);
	endtask
	task automatic t_pins;
		wreg(coe_pkg::ADDR_DIR, 8'h00);
		wreg(coe_pkg::ADDR_CMP_ONE_CTRL, 8'ha0);
		wreg(coe_pkg::ADDR_CMP_TWO_CTRL, 8'hb0);
		lvl[3:2] <= 2'h3;
		w8(4);
		chk("pins", 8'h0d, {4'h0, p1, e1, p2, e2});
		wreg(coe_pkg::ADDR_DIR, 8'h02);
		w8(2);
		chk("oe", 8'h02, {6'h0, e1, e2});
		wreg(coe_pkg::ADDR_CMP_ONE_CTRL, 8'hb0);
		w8(2);
		chk("inv", 8'h01, {6'h0, p1, e1});
		chk("cfg one", 8'hb0, c1);
		chk("cfg two", 8'hb0, c2);
		chk("on", 8'h03, {6'h0, on1, on2});
		wreg(coe_pkg::ADDR_CMP_ONE_CTRL, 8'ha0);
	endtask
	task automatic t_mirror;
		wreg(coe_pkg::ADDR_MIRROR_GATE, 8'hff);
		rreg(coe_pkg::ADDR_MIRROR_GATE, "mirror", 8'h83);
		lvl[3:2] <= 2'h0;
		w8(4);
		rreg(coe_pkg::ADDR_MIRROR_GATE, "mirror", 8'h43);
	endtask
	task automatic t_gate;
		wreg(coe_pkg::ADDR_CMP_TWO_CTRL, 8'h80);
		wreg(coe_pkg::ADDR_MIRROR_GATE, 8'h02);
		lvl[1] <= 1'b1;
		w8(4);
		chk("gate pin", 8'h01, {7'h0, tg});
		lvl[2:0] <= 3'h5;
		wreg(coe_pkg::ADDR_MIRROR_GATE, 8'h00);
		w8(6);
		chk("gate cmp", 8'h01, {7'h0, tg});
		lvl[2] <= 1'b0;
		wreg(coe_pkg::ADDR_MIRROR_GATE, 8'h01); // sync on while the comparator gates the timer
		w8(4);
		lvl[2] <= 1'b1;
		w8(8);
		chk("gate held", 8'h00, {7'h0, tg});
		lvl[0] <= 1'b0;
		w8(8);
		chk("gate fall", 8'h01, {7'h0, tg});
		lvl[2:0] <= 3'h1;
		w8(8);
		chk("gate rise", 8'h01, {7'h0, tg});
	endtask
	task automatic t_irq;
		slow <= 1'b1;
		w8(200); // bias settling before the flags are armed
		rreg(coe_pkg::ADDR_CMP_ONE_CTRL, "ctrl", 8'ha0);
		wreg(coe_pkg::ADDR_FLAG, 8'h00);
		wreg(coe_pkg::ADDR_ENABLE, 8'h18);
		wreg(coe_pkg::ADDR_IRQ_CTRL, 8'h03);
		lvl[3] <= 1'b1;
		w8(10);
		chk("irq", 8'h01, {7'h0, irq});
		wreg(coe_pkg::ADDR_IRQ_CTRL, 8'h01);
		w8(2);
		chk("irq gated", 8'h00, {7'h0, irq});
		rreg(coe_pkg::ADDR_FLAG, "flag", 8'h08);
		wreg(coe_pkg::ADDR_FLAG, 8'h00);
		rreg(coe_pkg::ADDR_MIRROR_GATE, "mirror", 8'h81);
		lvl[3] <= 1'b0;
		w8(10);
		rreg(coe_pkg::ADDR_FLAG, "return", 8'h00);
		lvl[3] <= 1'b1;
		w8(10);
		wreg(coe_pkg::ADDR_FLAG, 8'h00);
		rreg(coe_pkg::ADDR_CMP_ONE_CTRL, "ctrl", 8'he0);
		lvl[3] <= 1'b0;
		w8(10);
		rreg(coe_pkg::ADDR_FLAG, "refresh", 8'h08);
		wreg(coe_pkg::ADDR_FLAG, 8'h10);
		wreg(coe_pkg::ADDR_IRQ_CTRL, 8'h03);
		w8(2);
		chk("soft set", 8'h01, {7'h0, irq});
		rreg(coe_pkg::ADDR_FLAG, "flag", 8'h10);
	endtask
	task automatic stop_test;
		if (errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			errors++;
			stop_test();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_ref();
		t_pins();
		t_mirror();
		t_gate();
		t_irq();
		stop_test();
	end
endmodule
